// [cigr_pkg.sv]
// Package with constants and types for the configuration initialization controller.
package cigr_pkg;
    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned INIT_PULSE_WIDTH_NS = 1000;
    localparam int unsigned INIT_PULSE_CYCLES  =
        (INIT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FLOAT_PULSE_WIDTH_NS = 1000;
    localparam int unsigned FLOAT_PULSE_CYCLES =
        (FLOAT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W              = 16;
    localparam logic [CNT_W-1:0] CNT_RESET     = 16'h0000;

    // ==========================================================================
    // States
    // ==========================================================================
    typedef enum logic [1:0] {
        CIGR_IDLE  = 2'b00,
        CIGR_PULSE = 2'b01,
        CIGR_DONE  = 2'b11
    } cigr_state_type;
endpackage : cigr_pkg

// [cigr_pulse_if.sv]
// Interface carrying one pulser's trigger and pulse.
`timescale 1ns/100ps
`default_nettype none
interface cigr_pulse_if;
    logic trigger;
    logic pulse;
    modport ctrl (output trigger, input pulse);
    modport pulser (input trigger, output pulse);
endinterface : cigr_pulse_if
`default_nettype wire

// [cigr_pulser.sv]
// One-shot pulse generator of programmable width, restarted on each trigger.
`timescale 1ns/100ps
`default_nettype none
module cigr_pulser
    import cigr_pkg::*;
#(
    parameter int unsigned WIDTH_CYCLES = INIT_PULSE_CYCLES
) (
    input  wire logic     core_clk_i,
    input  wire logic     rstn_i,
    cigr_pulse_if.pulser  p
);
    // Widths outside the counter range cannot be counted.
    if (WIDTH_CYCLES < 1 || WIDTH_CYCLES >= (1 << CNT_W)) begin : g_bad_width
        $error("WIDTH_CYCLES out of range");
    end

    logic [CNT_W-1:0] cnt_r;
    logic             pulse_r;

    // ==========================================================================
    // Pulse counter
    // ==========================================================================
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt_r   <= CNT_RESET;
            pulse_r <= 1'b0;
        end else if (p.trigger) begin
            cnt_r   <= CNT_W'(WIDTH_CYCLES - 1);
            pulse_r <= 1'b1;
        end else if (cnt_r != CNT_RESET) begin
            cnt_r   <= cnt_r - 16'h0001;
        end else begin
            pulse_r <= 1'b0;
        end
    end
    assign p.pulse = pulse_r;
endmodule : cigr_pulser
`default_nettype wire

// [cigr_init_ctrl.sv]
// Initialization controller driving the global set/reset and output float nets.
// Operation
// - Pulse after power-up and after configuration ends.
// - Pulse generated automatically, no user request.
// - One dedicated global net feeds all registers.
// - Each register takes its defined initial value.
// - Controller drives the global set/reset net.
// - Outputs float via dedicated global float net.
// - Float applies to every general-purpose output type.
// - Pulse width exceeds all net delays.
// - Float pulser independent of reset pulser.
`timescale 1ns/100ps
`default_nettype none
module cigr_init_ctrl
    import cigr_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = INIT_PULSE_CYCLES,
    parameter int unsigned FLOAT_CYCLES = FLOAT_PULSE_CYCLES
) (
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic config_done_i,
    output var  logic global_set_reset_net_o,
    output var  logic global_output_float_net_o,
    output var  logic init_busy_o
);
    // ==========================================================================
    // Parameter checks
    // ==========================================================================
    // Both pulses need two cycles at least for the width checks below, and
    // must fit the pulse counters.
    if (RESET_CYCLES < 2 || RESET_CYCLES >= (1 << CNT_W)) begin : g_bad_reset_cycles
        $error("RESET_CYCLES out of range");
    end
    if (FLOAT_CYCLES < 2 || FLOAT_CYCLES >= (1 << CNT_W)) begin : g_bad_float_cycles
        $error("FLOAT_CYCLES out of range");
    end

    // ==========================================================================
    // Synchroniser for the configuration-done pin
    // ==========================================================================
    logic done_meta_r;
    logic done_sync_r;
    logic done_prev_r;
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            done_meta_r <= 1'b0;
            done_sync_r <= 1'b0;
            done_prev_r <= 1'b0;
        end else begin
            done_meta_r <= config_done_i;
            done_sync_r <= done_meta_r;
            done_prev_r <= done_sync_r;
        end
    end

    // ==========================================================================
    // Trigger sequencing
    // ==========================================================================
    cigr_state_type state_r;
    logic           trig;
    logic           done_rise;
    assign done_rise = done_sync_r & ~done_prev_r;
    // The first cycle after reset release counts as power-up.
    assign trig = (state_r == CIGR_IDLE) | done_rise;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_r <= CIGR_IDLE;
        end else begin
            unique case (state_r)
                CIGR_IDLE:  state_r <= CIGR_PULSE;
                CIGR_PULSE: state_r <= CIGR_DONE;
                CIGR_DONE:  state_r <= CIGR_DONE;
                default:    state_r <= CIGR_IDLE;
            endcase
        end
    end

    cigr_pulse_if rst_if ();
    cigr_pulse_if flt_if ();
    assign rst_if.trigger = trig;
    assign flt_if.trigger = trig;

    // Two separate pulser instances keep the float path independent of reset.
    cigr_pulser #(.WIDTH_CYCLES(RESET_CYCLES)) u_config_reset_pulser (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .p          (rst_if)
    );
    cigr_pulser #(.WIDTH_CYCLES(FLOAT_CYCLES)) u_config_float_pulser (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .p          (flt_if)
    );

    // ==========================================================================
    // Global net drivers
    // ==========================================================================
    // Nets are set on the first clock edge in reset and held asserted while reset lasts.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            global_set_reset_net_o    <= 1'b1;
            global_output_float_net_o <= 1'b1;
            init_busy_o               <= 1'b1;
        end else begin
            global_set_reset_net_o    <= rst_if.pulse | trig;
            global_output_float_net_o <= flt_if.pulse | trig;
            init_busy_o               <= rst_if.pulse | flt_if.pulse | trig;
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    a_powerup_reset: assert property (@(posedge core_clk_i)
        $rose(rstn_i) |-> ##[1:2] global_set_reset_net_o)
        else $error("no reset pulse after power-up");
    a_config_reset: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        done_rise |-> ##1 global_set_reset_net_o)
        else $error("no reset pulse after configuration");
    a_reset_width: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(rst_if.pulse) |-> rst_if.pulse [*2])
        else $error("reset pulse too short");
    a_float_follow: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        flt_if.pulse |=> global_output_float_net_o)
        else $error("float net not driven during float pulse");
    a_reset_follow: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rst_if.pulse |=> global_set_reset_net_o)
        else $error("reset net not driven during reset pulse");
    a_float_release: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (!flt_if.pulse && !trig) |=> !global_output_float_net_o)
        else $error("outputs held floating after pulse");
    a_reset_release: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (!rst_if.pulse && !trig) |=> !global_set_reset_net_o)
        else $error("reset net held after pulse");
    a_auto_start: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_r == CIGR_IDLE |=> state_r == CIGR_PULSE)
        else $error("power-up pulse not started automatically");

    // Sequencing, start of both pulsers and float pulse width.
    a_state_legal: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_r inside {CIGR_IDLE, CIGR_PULSE, CIGR_DONE})
        else $error("sequencer in an unused state");
    a_single_start: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_r == CIGR_DONE |=> state_r == CIGR_DONE)
        else $error("power-up trigger repeated without a reset");
    a_busy_start: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        trig |=> init_busy_o)
        else $error("busy flag low after a trigger");
    a_both_start: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        trig |=> (rst_if.pulse && flt_if.pulse))
        else $error("a pulser missed the trigger");
    a_reset_restart: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (trig && rst_if.pulse) |=> rst_if.pulse)
        else $error("restarted reset pulse dropped");
    a_sync_delay: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(done_meta_r) |=> done_rise)
        else $error("configuration end not seen after the synchroniser");
    a_done_edge_once: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        done_rise |=> !done_rise)
        else $error("configuration end seen twice for one rise");
    a_config_float: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        done_rise |-> ##1 global_output_float_net_o)
        else $error("outputs not floated after configuration");
    a_float_width: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(flt_if.pulse) |-> flt_if.pulse [*2])
        else $error("float pulse too short");

    // Behaviour while the controller is held in reset.
    a_reset_in_reset: assert property (@(posedge core_clk_i)
        !rstn_i |=> global_set_reset_net_o)
        else $error("reset net low while the controller is held in reset");
    a_float_in_reset: assert property (@(posedge core_clk_i)
        !rstn_i |=> global_output_float_net_o)
        else $error("outputs driven while the controller is held in reset");

    // Busy flag against the two nets.
    a_busy_nets: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (global_set_reset_net_o || global_output_float_net_o) |-> init_busy_o)
        else $error("busy flag low while a global net is active");
    a_busy_release: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !(rst_if.pulse || flt_if.pulse || trig) |=> !init_busy_o)
        else $error("busy flag held after both pulses ended");

    // ==========================================================================
    // Width measurement
    // ==========================================================================
    // Each counter holds the cycles its net has stood high since the latest
    // trigger, so a restarted pulse is measured from the restart.
    localparam logic [CNT_W:0] LEN_ZERO = {(CNT_W+1){1'b0}};
    localparam logic [CNT_W:0] LEN_ONE  = {{CNT_W{1'b0}}, 1'b1};
    logic [CNT_W:0] rst_len_r;
    logic [CNT_W:0] flt_len_r;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || trig) begin
            rst_len_r <= LEN_ZERO;
        end else if (global_set_reset_net_o) begin
            rst_len_r <= rst_len_r + LEN_ONE;
        end else begin
            rst_len_r <= LEN_ZERO;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || trig) begin
            flt_len_r <= LEN_ZERO;
        end else if (global_output_float_net_o) begin
            flt_len_r <= flt_len_r + LEN_ONE;
        end else begin
            flt_len_r <= LEN_ZERO;
        end
    end

    a_reset_length: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $fell(global_set_reset_net_o) |-> (rst_len_r == RESET_CYCLES + 1))
        else $error("reset net width differs from the set width");
    a_float_length: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $fell(global_output_float_net_o) |-> (flt_len_r == FLOAT_CYCLES + 1))
        else $error("float net width differs from the set width");
endmodule : cigr_init_ctrl
`default_nettype wire

// [cigr_user_model.sv]
// Model of the user registers and output buffers fed by the global nets.
`timescale 1ns/100ps
`default_nettype none
module cigr_user_model #(
    parameter logic INIT_VALUE = 1'h1
) (
    input  wire logic core_clk_i,
    input  wire logic global_set_reset_net_i,
    input  wire logic global_output_float_net_i,
    input  wire logic data_i,
    input  wire logic drive_en_i,
    output var  logic q_o,
    output wire logic pad_o
);
    always_ff @(posedge core_clk_i or posedge global_set_reset_net_i) begin
        if (global_set_reset_net_i) begin
            q_o <= INIT_VALUE;
        end else begin
            q_o <= data_i;
        end
    end
    assign pad_o = (global_output_float_net_i || !drive_en_i) ? 1'hZ : q_o;
endmodule : cigr_user_model
`default_nettype wire

// [tb.sv]
// Testbench for the configuration initialization controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int RST_W = 4;
    localparam int FLT_W = 6;
    logic core_clk_i    = 1'h0;
    logic rstn_i        = 1'h0;
    logic config_done_i = 1'h0;
    logic data          = 1'h0;
    logic global_set_reset_net, global_output_float_net, busy, q;
    wire  pad;
    int   fail_count    = 0;
    int   checks_done   = 0;
    cigr_init_ctrl #(.RESET_CYCLES(RST_W), .FLOAT_CYCLES(FLT_W)) u_cigr_init_ctrl (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .config_done_i(config_done_i),
        .global_set_reset_net_o(global_set_reset_net), .global_output_float_net_o(global_output_float_net), .init_busy_o(busy));
    cigr_user_model u_cigr_user_model (
        .core_clk_i(core_clk_i), .global_set_reset_net_i(global_set_reset_net),
        .global_output_float_net_i(global_output_float_net), .data_i(data), .drive_en_i(1'h1),
        .q_o(q), .pad_o(pad));
    always #5 core_clk_i = ~core_clk_i;
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // Counts the cycles each net stays high and checks the float-minus-reset width gap.
    task automatic measure;
        int ws, wf, n;
        ws = 0; wf = 0; n = 0;
        while ((global_set_reset_net === 1'h1 || global_output_float_net === 1'h1) && n < 300) begin
            ws += int'(global_set_reset_net === 1'h1);
            wf += int'(global_output_float_net === 1'h1);
            @(posedge core_clk_i); #1;
            n++;
        end
        check("reset_long", 8'(ws >= RST_W), 8'h01);
        check("float_gap", 8'(wf - ws), 8'(FLT_W - RST_W));
        repeat (2) @(posedge core_clk_i);
        #1;
        check("busy_low", 8'(busy), 8'h00);
        data = 1'h0;
        @(posedge core_clk_i); #1;
        check("q_clocked", 8'(q), 8'h00);
        check("pad_driven", 8'(pad), 8'h00);
    endtask : measure
    task automatic t_reset;
        check("gsr_rst", 8'(global_set_reset_net), 8'h01);
        check("gts_rst", 8'(global_output_float_net), 8'h01);
        check("q_init", 8'(q), 8'h01);
        check("pad_float", 8'(pad), {7'h00, 1'hZ});
        check("busy_rst", 8'(busy), 8'h01);
    endtask : t_reset
    task automatic t_config;
        int n;
        n = 0;
        config_done_i = 1'h1;
        while (global_set_reset_net !== 1'h1 && n < 8) begin
            @(posedge core_clk_i); #1;
            n++;
        end
        check("gsr_cfg", 8'(global_set_reset_net), 8'h01);
        check("q_forced", 8'(q), 8'h01);
        check("pad_cfg", 8'(pad), {7'h00, 1'hZ});
        check("busy_cfg", 8'(busy), 8'h01);
        measure();
        config_done_i = 1'h0;
    endtask : t_config
    initial begin
        repeat (20) @(posedge core_clk_i);
        #1;
        t_reset();
        rstn_i = 1'h1;
        measure();
        t_config();
        repeat (3) @(posedge core_clk_i);
        #1;
        t_config();
        print_verdict();
    end
    initial begin
        repeat (2000) @(posedge core_clk_i);
        fail_count++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
